// ==== logic/port_flow_control_config.sv ====
// Port 1 flow control configuration and status register
// Behaviour
// [RQ1] Bit 6 gates half-duplex backpressure
// [RQ2] Bit 5 reads duplex: 1 half
// [RQ3] Bit 4 reads resolved receive pause
// [RQ4] Bit 3 reads resolved transmit pause
// [RQ5] Bit 2 manual receive pause enable
// [RQ6] Bit 1 manual transmit pause enable
// [RQ7] Select clear, autoneg on: negotiated result in full-duplex
// [RQ8] Select set: manual bits rule full-duplex
// [RQ9] Control defaults from straps, reload updates
// [RQ10] Status follows straps and reload too
// [RQ11] Phy advertisement untouched by writes
// [RQ12] Upper bits zero, status writes ignored
`timescale 1ns/1ps
`default_nettype none
module port_flow_control_config
	import port_fc_pkg::*;
(
	input  wire logic                         SYS_CLK,
	input  wire logic                         RESET_N,
	input  wire logic [port_fc_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic                         REG_WR,
	input  wire logic                         REG_RD,
	input  wire logic [port_fc_pkg::DATA_W-1:0] REG_WDATA,
	output logic      [port_fc_pkg::DATA_W-1:0] REG_RDATA,
	input  wire logic                         BACKPRESSURE_DEFAULT_STRAP,
	input  wire logic                         PAUSE_ENABLE_DEFAULT_STRAP,
	input  wire logic                         MANUAL_SELECT_DEFAULT_STRAP,
	input  wire logic                         STRAP_RELOAD,
	input  wire logic                         AUTONEG_ENABLE,
	input  wire logic                         LINK_DUPLEX_HALF,
	input  wire logic                         NEG_RX_PAUSE,
	input  wire logic                         NEG_TX_PAUSE,
	output logic                              BACKPRESSURE_ENABLE,
	output logic                              RX_PAUSE_ACTIVE,
	output logic                              TX_PAUSE_ACTIVE
);
	import port_fc_pkg::*;

	typedef struct packed {
		fc_state_t  state;
		logic       backpressure_enable;
		logic       rx_pause_enable;
		logic       tx_pause_enable;
		logic       manual_pause_select;
		logic       current_duplex_status;
		logic       current_rx_pause_status;
		logic       current_tx_pause_status;
		logic       reload_prev;
		logic [1:0] warm;
		logic [DATA_W-1:0] rdata;
	} regs_t;

	regs_t st_ff;
	regs_t nxt_st;
	logic [7:0] pins_sync;
	logic bp_strap;
	logic pause_strap;
	logic manual_strap;
	logic reload_lvl;
	logic an_on;
	logic dup_half;
	logic neg_rx;
	logic neg_tx;
	logic res_rx;
	logic res_tx;

	// Resolve one pause direction
	function automatic logic resolve(input logic manual_sel, input logic autoneg,
			input logic half, input logic manual_en, input logic negotiated);
		logic r;
		r = 1'b0;
		if (half) begin
			r = 1'b0;
		end else if (manual_sel || !autoneg) begin
			r = manual_en;
		end else begin
			r = negotiated;
		end
		return r;
	endfunction

	pin_sync #(
		.WIDTH(8)
	) u_sync (
		.SYS_CLK(SYS_CLK),
		.RESET_N(RESET_N),
		.D      ({BACKPRESSURE_DEFAULT_STRAP, PAUSE_ENABLE_DEFAULT_STRAP,
			MANUAL_SELECT_DEFAULT_STRAP, STRAP_RELOAD, AUTONEG_ENABLE,
			LINK_DUPLEX_HALF, NEG_RX_PAUSE, NEG_TX_PAUSE}),
		.Q      (pins_sync)
	);

	assign bp_strap     = pins_sync[7];
	assign pause_strap  = pins_sync[6];
	assign manual_strap = pins_sync[5];
	assign reload_lvl   = pins_sync[4];
	assign an_on        = pins_sync[3];
	assign dup_half     = pins_sync[2];
	assign neg_rx       = pins_sync[1];
	assign neg_tx       = pins_sync[0];

	// [RQ7] Pick negotiated or manual
	// [RQ8] Manual select uses enable bits
	assign res_rx = resolve(st_ff.manual_pause_select, an_on, dup_half,
		st_ff.rx_pause_enable, neg_rx);
	assign res_tx = resolve(st_ff.manual_pause_select, an_on, dup_half,
		st_ff.tx_pause_enable, neg_tx);

	always_comb begin
		nxt_st             = st_ff;
		nxt_st.reload_prev = reload_lvl;
		case (st_ff.state)
			ST_RESET: begin
				// Wait until synchroniser holds real strap levels
				nxt_st.warm = st_ff.warm + 2'h1;
				if (st_ff.warm == 2'(SYNC_STAGES - 1)) begin
					nxt_st.state = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				// [RQ9] Strap defaults after release
				nxt_st.backpressure_enable = bp_strap;
				nxt_st.rx_pause_enable     = pause_strap;
				nxt_st.tx_pause_enable     = pause_strap;
				nxt_st.manual_pause_select = manual_strap;
				nxt_st.state               = ST_RUN;
			end
			ST_RUN: begin
				if (reload_lvl && !st_ff.reload_prev) begin
					// [RQ9] Loader rewrite takes over
					nxt_st.backpressure_enable = bp_strap;
					nxt_st.rx_pause_enable     = pause_strap;
					nxt_st.tx_pause_enable     = pause_strap;
					nxt_st.manual_pause_select = manual_strap;
				end else if (REG_WR && REG_ADDR == PORT1_FLOW_CONTROL_OFFSET) begin
					// [RQ12] Only control bits written
					// [RQ11] No path to phy advertisement
					nxt_st.backpressure_enable = REG_WDATA[BIT_BACKPRESSURE];
					nxt_st.rx_pause_enable     = REG_WDATA[BIT_RX_PAUSE_ENABLE];
					nxt_st.tx_pause_enable     = REG_WDATA[BIT_TX_PAUSE_ENABLE];
					nxt_st.manual_pause_select = REG_WDATA[BIT_MANUAL_SELECT];
				end
			end
			default: begin
				nxt_st.state = ST_RESET;
			end
		endcase
		// [RQ2] Duplex status tracks link
		// [RQ10] Status follows live settings
		nxt_st.current_duplex_status   = dup_half ? DUPLEX_HALF : DUPLEX_FULL;
		// [RQ3] Receive pause readback
		nxt_st.current_rx_pause_status = res_rx;
		// [RQ4] Transmit pause readback
		nxt_st.current_tx_pause_status = res_tx;
		nxt_st.rdata = '0;
		if (REG_RD && REG_ADDR == PORT1_FLOW_CONTROL_OFFSET) begin
			// [RQ12] Reserved bits read zero
			nxt_st.rdata[BIT_BACKPRESSURE]    = st_ff.backpressure_enable;
			nxt_st.rdata[BIT_CUR_DUPLEX]      = st_ff.current_duplex_status;
			nxt_st.rdata[BIT_CUR_RX_PAUSE]    = st_ff.current_rx_pause_status;
			nxt_st.rdata[BIT_CUR_TX_PAUSE]    = st_ff.current_tx_pause_status;
			// [RQ5] Receive enable readback
			nxt_st.rdata[BIT_RX_PAUSE_ENABLE] = st_ff.rx_pause_enable;
			// [RQ6] Transmit enable readback
			nxt_st.rdata[BIT_TX_PAUSE_ENABLE] = st_ff.tx_pause_enable;
			nxt_st.rdata[BIT_MANUAL_SELECT]   = st_ff.manual_pause_select;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff <= '{state: ST_RESET, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign REG_RDATA           = st_ff.rdata;
	// [RQ1] Backpressure only in half duplex
	assign BACKPRESSURE_ENABLE = st_ff.backpressure_enable & st_ff.current_duplex_status;
	assign RX_PAUSE_ACTIVE     = st_ff.current_rx_pause_status;
	assign TX_PAUSE_ACTIVE     = st_ff.current_tx_pause_status;
endmodule
`default_nettype wire

// ==== logic/port_fc_pkg.sv ====
// Constants for the port flow control register
package port_fc_pkg;
	localparam logic [11:0] PORT1_FLOW_CONTROL_OFFSET = 12'h1a0;
	localparam int          ADDR_W                    = 12;
	localparam int          DATA_W                    = 32;
	localparam int          BIT_MANUAL_SELECT         = 0;
	localparam int          BIT_TX_PAUSE_ENABLE       = 1;
	localparam int          BIT_RX_PAUSE_ENABLE       = 2;
	localparam int          BIT_CUR_TX_PAUSE          = 3;
	localparam int          BIT_CUR_RX_PAUSE          = 4;
	localparam int          BIT_CUR_DUPLEX            = 5;
	localparam int          BIT_BACKPRESSURE          = 6;
	localparam logic [6:0]  WRITABLE_MASK             = 7'h47;
	localparam int          SYNC_STAGES               = 2;
	localparam logic [1:0]  SYNC_RESET                = 2'h0;
	localparam logic        CTRL_RESET                = 1'b0;
	localparam logic        DUPLEX_HALF               = 1'b1;
	localparam logic        DUPLEX_FULL               = 1'b0;

	typedef enum logic [2:0] {
		ST_RESET   = 3'b001,
		ST_CAPTURE = 3'b010,
		ST_RUN     = 3'b100
	} fc_state_t;
endpackage

// ==== logic/pin_sync.sv ====
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             SYS_CLK,
	input  wire logic             RESET_N,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	typedef struct packed {
		logic [WIDTH-1:0] first_ff;
		logic [WIDTH-1:0] second_ff;
	} sync_t;

	sync_t st_ff;
	sync_t nxt_st;

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.first_ff  = D;
		nxt_st.second_ff = st_ff.first_ff;
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign Q = st_ff.second_ff;
endmodule
`default_nettype wire

// ==== dv/pfc_monitor.sv ====
// Assertion checker for the flow control register
`timescale 1ns/1ps
`default_nettype none
module pfc_monitor (
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic [11:0] REG_ADDR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        LINK_DUPLEX_HALF,
	input wire logic        BACKPRESSURE_ENABLE,
	input wire logic        RX_PAUSE_ACTIVE,
	input wire logic        TX_PAUSE_ACTIVE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_rd;
		REG_RD && REG_ADDR == 12'h1a0;
	endsequence
	chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("idle data");
	chk_rsvd_zero: assert property (REG_RDATA[31:7] == 25'h0)
		else $error("reserved set");
	chk_unmap_zero: assert property (REG_RD && REG_ADDR != 12'h1a0 |=> REG_RDATA == 32'h0)
		else $error("unmapped");
	chk_half_nopause: assert property (LINK_DUPLEX_HALF[*5] |->
		!RX_PAUSE_ACTIVE && !TX_PAUSE_ACTIVE) else $error("half pause");
	chk_bp_gate: assert property ((!LINK_DUPLEX_HALF)[*5] |-> !BACKPRESSURE_ENABLE)
		else $error("backpressure");
	chk_dup_read: assert property ($stable(LINK_DUPLEX_HALF)[*6] ##0 s_rd |=>
		REG_RDATA[5] == $past(LINK_DUPLEX_HALF)) else $error("duplex");
	chk_rx_read: assert property (s_rd ##0 $stable(RX_PAUSE_ACTIVE)[*2] |->
		REG_RDATA[4] == RX_PAUSE_ACTIVE) else $error("rx pause");
	chk_tx_read: assert property (s_rd ##0 $stable(TX_PAUSE_ACTIVE)[*2] |->
		REG_RDATA[3] == TX_PAUSE_ACTIVE) else $error("tx pause");
endmodule
bind port_flow_control_config pfc_monitor i_mon (.*);
`default_nettype wire

// ==== dv/port_flow_control_config_tb_top.sv ====
// Bench for the flow control register
`timescale 1ns/1ps
`default_nettype none
module port_flow_control_config_tb_top;
	logic        clk = 0;
	logic        rstn, wre, rde, rl, an, hd, nrx, ntx, bpe, rxa, txa;
	logic [2:0]  st;
	logic [11:0] a;
	logic [31:0] rdat, v, e, c;
	int          seed, fail_count, cmp_count;
	port_flow_control_config i_dut (.SYS_CLK(clk), .RESET_N(rstn), .REG_ADDR(a), .REG_WR(wre),
		.REG_RD(rde), .REG_WDATA(e), .REG_RDATA(rdat), .BACKPRESSURE_DEFAULT_STRAP(st[0]),
		.PAUSE_ENABLE_DEFAULT_STRAP(st[1]), .MANUAL_SELECT_DEFAULT_STRAP(st[2]),
		.STRAP_RELOAD(rl), .AUTONEG_ENABLE(an), .LINK_DUPLEX_HALF(hd), .NEG_RX_PAUSE(nrx),
		.NEG_TX_PAUSE(ntx), .BACKPRESSURE_ENABLE(bpe), .RX_PAUSE_ACTIVE(rxa), .TX_PAUSE_ACTIVE(txa));
	always #25 clk = ~clk;
	function automatic logic [31:0] want(input logic [6:0] x);
		logic m;
		m = x[0] | !an;
		return {25'h0, x[6], hd, !hd & (m ? x[2] : nrx), !hd & (m ? x[1] : ntx), x[2:0]};
	endfunction
	task acc(input logic w, input logic [11:0] ad);
		a = ad;
		wre = w;
		rde = !w;
		@(negedge clk);
		{wre, rde} = 2'h0;
		v = rdat;
	endtask
	task chk(input string n, input logic [31:0] s, x);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask
	task end_of_test;
		$display("%0d checks %0d bad", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#150us;
		fail_count++;
		end_of_test();
	end
	initial begin
		seed = 45;
		{rstn, wre, rde, rl, an, hd, nrx, ntx, a, e} = '0;
		st = 3'($random(seed));
		repeat (10) @(negedge clk);
		rstn = 1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 22; i++) begin
			if (i == 21)
				{st, rl} = {~st, 1'b1};
			c = {25'h0, st[0], 3'h0, st[1], st[1], st[2]};
			if (i % 21 != 0) begin
				{an, hd, nrx, ntx} = 4'($random(seed));
				e = (i == 1) ? 32'hffffffff : $random(seed);
				acc(1'b1, 12'h1a0);
				c = e & 32'h47;
			end
			repeat (6) @(negedge clk);
			acc(1'b0, 12'h1a0);
			e = want(c[6:0]);
			chk("reg", v, e);
			chk("out", {29'h0, bpe, rxa, txa}, {29'h0, c[6] & hd, e[4:3]});
			acc(1'b0, 12'h1a4);
			chk("unmapped", v, 32'h0);
			$display("test %0d over", i);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
